// *** hdl/cis_map.vh ***
/*
  Register offsets, field positions, reset values and timing counts of the
  contact input scanner. Assumes a 250 MHz core clock and byte addresses
  on the plain register port.
*/
// What this block does
// R1: Ignore input changes stable under 2 msec
// R2: Sample every debounced input each millisecond
// R3: Per-point config: status, change latch, counting
// R4: Per-point pulse counter, 12 or 24 bits
// R5: Record accepted transitions with scan time tag
// R6: Pass only pulses within configured width range
// R7: Per-point chatter filter suppresses oscillating alarms
// R8: Field inputs toggle no faster than 200 Hz
// R9: 32 inputs as four groups of eight
// R10: Sequence four field plus zero, full-scale channels
// R11: 80 msec per channel, refresh within 600
// R12: 13-bit signed results, saturate at 2047/4095
// R13: Subtract zero reference from field results
// R14: Conversion results readable from register memory
// R15: Raw reference readings readable like data points
// R16: Change latch holds until master reads it
`ifndef CIS_MAP_VH
`define CIS_MAP_VH

// Timing
`define CIS_CLK_HZ 250000000
`define CIS_MS_PER_S 1000
`define CIS_DEBOUNCE_MS 2
`define CIS_CONV_MS 80
`define CIS_MAX_AGE_MS 600

// Register byte offsets
`define CIS_OFS_CTRL 8'h00
`define CIS_OFS_STATUS 8'h04
`define CIS_OFS_CHANGE 8'h08
`define CIS_OFS_IRQ_STAT 8'h0c
`define CIS_OFS_IRQ_MASK 8'h10
`define CIS_OFS_PW_LIMIT 8'h14
`define CIS_OFS_CHATTER 8'h18
`define CIS_OFS_CFG_PTR 8'h1c
`define CIS_OFS_CFG_DATA 8'h20
`define CIS_OFS_ACC_DATA 8'h24
`define CIS_OFS_EVT_COUNT 8'h28
`define CIS_OFS_EVT_TIME 8'h2c
`define CIS_OFS_EVT_INFO 8'h30
`define CIS_OFS_ADC_BASE 8'h40

// Control fields
`define CIS_CTRL_SCAN_EN 0
`define CIS_CTRL_ADC_EN 1
`define CIS_CTRL_UNIPOLAR 2
`define CIS_CTRL_INV_LO 4
`define CIS_CTRL_RESET 32'h0000_0000

// Per-point config fields
`define CIS_CFG_STATUS 0
`define CIS_CFG_CHANGE 1
`define CIS_CFG_COUNT 2
`define CIS_CFG_WIDE 3
`define CIS_CFG_EVENT 4
`define CIS_CFG_CHATTER 5

// Interrupt status bits
`define CIS_IRQ_EVENT 0
`define CIS_IRQ_OVERFLOW 1
`define CIS_IRQ_CHANGE 2
`define CIS_IRQ_ADC 3
`define CIS_IRQ_CHATTER 4

// Reset values of limits
`define CIS_PW_RESET 32'hffff_0000
`define CIS_CHATTER_RESET 32'h0000_0864

// Analog channels and saturation
`define CIS_CH_ZERO 3'h4
`define CIS_CH_FULL 3'h5
`define CIS_BIP_MAX 14'sh07ff
`define CIS_UNI_MAX 14'sh0fff

`endif

// *** hdl/cis_debounce.v ***
/*
  One contact input: two-stage synchroniser and millisecond debouncer.
  Assumes the tick is a one-cycle pulse once per millisecond.
*/
`timescale 1ns/1ps
`default_nettype none
module cis_debounce #(
  parameter STABLE_MS = 2
)(
  input wire clock,
  input wire arst_n,
  input wire rawIn,
  input wire msTick,
  output reg levelOut
);
  // Synchroniser stages; syncA feeds only syncB
  reg syncA;
  reg syncB;
  // Ticks seen while the input differs from the accepted level
  reg [3:0] diffCnt;

  ////////////////////////////////////////////////////////////////////////////
  // A return to the old level at any cycle restarts the wait, so bounces
  // shorter than the stable time never reach the scanner
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      diffCnt <= 4'h0;
      levelOut <= 1'b0;
    end
    else
    begin
      syncA <= rawIn;
      syncB <= syncA;
      if (syncB == levelOut)
        diffCnt <= 4'h0; // [R1]
      else if (msTick)
      begin
        if (diffCnt == STABLE_MS[3:0])
        begin
          levelOut <= syncB; // [R1]
          diffCnt <= 4'h0;
        end
        else
          diffCnt <= diffCnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/cis_scanner.v ***
/*
  Contact input scanner top: debounce, millisecond scan, per-point status,
  change latch, pulse counting, time-tagged events, chatter filter, and the
  six-channel converter sequencer with zero correction.
  Assumes the converter handshake runs on this clock and the register
  master follows the plain strobe protocol.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cis_map.vh"
module cis_scanner #(
  parameter TICK_CYCLES = `CIS_CLK_HZ / `CIS_MS_PER_S,
  parameter POINTS = 32,
  parameter EVT_DEPTH = 8
)(
  input wire clock,
  input wire arst_n,
  input wire [31:0] contactIn,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [31:0] regRdData,
  output reg [2:0] adcMuxSel,
  output reg adcStart,
  input wire adcDone,
  input wire [12:0] adcData,
  output wire irq
);
  localparam CONV_MS = `CIS_CONV_MS;
  localparam S_IDLE = 2'b01;
  localparam S_SCAN = 2'b10;

  // Millisecond timebase and time tag
  reg [17:0] tickCnt_reg;
  reg msTick;
  reg [23:0] msTime_reg;
  // Software registers
  reg [31:0] ctrl_reg;
  reg [31:0] pwLimit_reg;
  reg [31:0] chatter_reg;
  reg [4:0] cfgPtr_reg;
  reg [5:0] irqStat_reg;
  reg [5:0] irqMask_reg;
  // Per-point state memories
  reg [5:0] cfgMem [0:31];
  reg [15:0] widthMem [0:31];
  reg [23:0] accMem [0:31];
  reg [3:0] chatMem [0:31];
  reg [31:0] prevLvl_reg;
  reg [31:0] filtLvl_reg;
  reg [31:0] change_reg;
  reg [31:0] chatHold_reg;
  reg [31:0] snap_reg;
  // Scan sequencer
  reg [1:0] state_reg;
  reg [4:0] scanPtr_reg;
  reg [7:0] winCnt_reg;
  reg winEnd_reg;
  // Event store
  reg [29:0] evtMem [0:EVT_DEPTH-1];
  reg [2:0] evtWr_reg;
  reg [2:0] evtRd_reg;
  reg [3:0] evtCount_reg;
  // Converter sequencer and results
  reg [2:0] adcChan_reg;
  reg [6:0] slotCnt_reg;
  reg [12:0] adcRaw_reg;
  reg [12:0] adcRes [0:5];
  wire [31:0] dbLevel;
  integer k;
  // Loop index of the combinational status view only
  integer j;

  ////////////////////////////////////////////////////////////////////////////
  // One debouncer per contact, grouped in fours of eight by common return
  genvar g;
  generate
    for (g = 0; g < POINTS; g = g + 1)
    begin : gDeb
      cis_debounce #(.STABLE_MS(`CIS_DEBOUNCE_MS)) uDeb (
        .clock(clock),
        .arst_n(arst_n),
        .rawIn(contactIn[g]),
        .msTick(msTick),
        .levelOut(dbLevel[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Combinational view of the point under scan
  wire [4:0] p = scanPtr_reg;
  wire [5:0] pCfg = cfgMem[p];
  wire lvl = snap_reg[p];
  wire prv = prevLvl_reg[p];
  wire [15:0] w = widthMem[p];
  wire edgeSeen = (state_reg == S_SCAN) && (lvl != prv);
  // An edge leaving a level held less than the minimum width is discarded
  wire accepted = edgeSeen && (w >= pwLimit_reg[15:0]); // [R6]
  wire pulseOk = edgeSeen && prv && !lvl && (w >= pwLimit_reg[15:0])
    && (w <= pwLimit_reg[31:16]); // [R6]
  wire quiet = !(pCfg[`CIS_CFG_CHATTER] && chatHold_reg[p]); // [R7]
  wire doEvent = accepted && quiet && pCfg[`CIS_CFG_EVENT];
  wire evtPop = regRdStb && (regAddr == `CIS_OFS_EVT_INFO) && (evtCount_reg != 4'h0);
  wire evtPush = doEvent && (evtCount_reg != EVT_DEPTH[3:0]);
  // Saturates so a busy point never wraps back to a quiet count
  wire [3:0] chatNew = (chatMem[p] == 4'hf) ? 4'hf : chatMem[p] + {3'h0, accepted};

  ////////////////////////////////////////////////////////////////////////////
  // Timebase: one tick a millisecond, free-running time tag
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tickCnt_reg <= 18'h0;
      msTick <= 1'b0;
      msTime_reg <= 24'h0;
    end
    else
    begin
      msTick <= (tickCnt_reg == TICK_CYCLES[17:0] - 18'h1);
      if (tickCnt_reg == TICK_CYCLES[17:0] - 18'h1)
        tickCnt_reg <= 18'h0;
      else
        tickCnt_reg <= tickCnt_reg + 18'h1;
      if (msTick)
        msTime_reg <= msTime_reg + 24'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan: snapshot all points on the tick, then walk them one per cycle
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= S_IDLE;
      scanPtr_reg <= 5'h0;
      snap_reg <= 32'h0;
      winCnt_reg <= 8'h0;
      winEnd_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (msTick && ctrl_reg[`CIS_CTRL_SCAN_EN])
          begin
            // Group polarity flips eight points at a time
            for (k = 0; k < POINTS; k = k + 1)
              snap_reg[k] <= dbLevel[k] ^ ctrl_reg[`CIS_CTRL_INV_LO + k / 8]; // [R9] [R2]
            scanPtr_reg <= 5'h0;
            winEnd_reg <= (winCnt_reg >= chatter_reg[7:0]);
            winCnt_reg <= (winCnt_reg >= chatter_reg[7:0]) ? 8'h0 : winCnt_reg + 8'h1;
            state_reg <= S_SCAN;
          end
        end
        S_SCAN:
        begin
          scanPtr_reg <= scanPtr_reg + 5'h1;
          if (scanPtr_reg == POINTS[4:0] - 5'h1)
            state_reg <= S_IDLE;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-point processing of the point under scan
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prevLvl_reg <= 32'h0;
      filtLvl_reg <= 32'h0;
      chatHold_reg <= 32'h0;
      for (k = 0; k < POINTS; k = k + 1)
      begin
        widthMem[k] <= 16'h0;
        accMem[k] <= 24'h0;
        chatMem[k] <= 4'h0;
      end
    end
    else if (state_reg == S_SCAN)
    begin
      if (edgeSeen)
      begin
        prevLvl_reg[p] <= lvl;
        widthMem[p] <= 16'h0;
      end
      else if (w != 16'hffff)
        widthMem[p] <= w + 16'h1;
      if (accepted)
        filtLvl_reg[p] <= lvl; // [R3]
      if (pulseOk && pCfg[`CIS_CFG_COUNT])
        // Narrow counters wrap at twelve bits
        accMem[p] <= pCfg[`CIS_CFG_WIDE] ? accMem[p] + 24'h1
          : {12'h0, accMem[p][11:0] + 12'h1}; // [R4]
      // Too many transitions in one window hold the point's alarms off
      if (winEnd_reg)
      begin
        chatHold_reg[p] <= (chatNew > chatter_reg[11:8]); // [R7]
        chatMem[p] <= 4'h0;
      end
      else if (chatMem[p] != 4'hf)
        chatMem[p] <= chatNew;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event store: point, new level and scan time tag
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      evtWr_reg <= 3'h0;
      evtRd_reg <= 3'h0;
      evtCount_reg <= 4'h0;
    end
    else
    begin
      if (evtPush)
      begin
        evtMem[evtWr_reg] <= {p, lvl, msTime_reg}; // [R5]
        evtWr_reg <= evtWr_reg + 3'h1;
      end
      if (evtPop)
        evtRd_reg <= evtRd_reg + 3'h1;
      evtCount_reg <= evtCount_reg + {3'h0, evtPush} - {3'h0, evtPop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter sequencer: one slot a channel, six slots a pass
  function [12:0] sat;
    input signed [13:0] v;
    input uni;
    reg signed [13:0] lim;
    begin
      lim = uni ? `CIS_UNI_MAX : `CIS_BIP_MAX;
      if (v > lim)
        sat = lim[12:0]; // [R12]
      else if (uni && v < 14'sh0000)
        sat = 13'h0000;
      else if (!uni && v < -lim)
        sat = 13'h0000 - lim[12:0];
      else
        sat = v[12:0];
    end
  endfunction

  wire slotEnd = msTick && (slotCnt_reg == CONV_MS[6:0] - 7'h1);
  wire [13:0] rawExt = {adcRaw_reg[12], adcRaw_reg};
  wire [13:0] zeroExt = {adcRes[4][12], adcRes[4]};
  wire adcPass = slotEnd && (adcChan_reg == `CIS_CH_FULL);

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      adcChan_reg <= 3'h0;
      slotCnt_reg <= 7'h0;
      adcRaw_reg <= 13'h0;
      adcStart <= 1'b0;
      adcMuxSel <= 3'h0;
      for (k = 0; k < 6; k = k + 1)
        adcRes[k] <= 13'h0;
    end
    else
    begin
      adcStart <= 1'b0;
      adcMuxSel <= adcChan_reg; // [R10]
      if (adcDone)
        adcRaw_reg <= adcData;
      if (!ctrl_reg[`CIS_CTRL_ADC_EN])
      begin
        adcChan_reg <= 3'h0;
        slotCnt_reg <= 7'h0;
      end
      else if (msTick)
      begin
        // Start at slot begin; 6 x 80 ms keeps every result under 600 ms old
        if (slotCnt_reg == 7'h0)
          adcStart <= 1'b1; // [R11]
        if (slotEnd)
        begin
          slotCnt_reg <= 7'h0;
          if (adcChan_reg >= `CIS_CH_ZERO)
            adcRes[adcChan_reg] <= sat(rawExt, ctrl_reg[`CIS_CTRL_UNIPOLAR]); // [R15]
          else
            adcRes[adcChan_reg] <= sat(rawExt - zeroExt, ctrl_reg[`CIS_CTRL_UNIPOLAR]); // [R13]
          adcChan_reg <= (adcChan_reg == `CIS_CH_FULL) ? 3'h0 : adcChan_reg + 3'h1; // [R10]
        end
        else
          slotCnt_reg <= slotCnt_reg + 7'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, change latch and interrupt status; sets beat clears
  wire changeRd = regRdStb && (regAddr == `CIS_OFS_CHANGE);
  reg [31:0] changeSet;
  reg [5:0] irqSet;
  always @*
  begin
    changeSet = 32'h0;
    if (accepted && quiet && pCfg[`CIS_CFG_CHANGE])
      changeSet[p] = 1'b1;
    irqSet = 6'h0;
    irqSet[`CIS_IRQ_EVENT] = evtPush;
    irqSet[`CIS_IRQ_OVERFLOW] = doEvent && !evtPush;
    irqSet[`CIS_IRQ_CHANGE] = |changeSet;
    irqSet[`CIS_IRQ_ADC] = adcPass;
    irqSet[`CIS_IRQ_CHATTER] = winEnd_reg && (state_reg == S_SCAN)
      && pCfg[`CIS_CFG_CHATTER] && (chatNew > chatter_reg[11:8]); // [R7]
  end

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg <= `CIS_CTRL_RESET;
      pwLimit_reg <= `CIS_PW_RESET;
      chatter_reg <= `CIS_CHATTER_RESET;
      cfgPtr_reg <= 5'h0;
      irqStat_reg <= 6'h0;
      irqMask_reg <= 6'h0;
      change_reg <= 32'h0;
      for (k = 0; k < POINTS; k = k + 1)
        cfgMem[k] <= 6'h0;
    end
    else
    begin
      // Latch stays until read; a change in the read cycle survives
      change_reg <= (changeRd ? 32'h0 : change_reg) | changeSet; // [R16]
      irqStat_reg <= (irqStat_reg & ~((regWrStb && regAddr == `CIS_OFS_IRQ_STAT)
        ? regWrData[5:0] : 6'h0)) | irqSet;
      if (regWrStb)
      begin
        case (regAddr)
          `CIS_OFS_CTRL: ctrl_reg <= {24'h0, regWrData[7:4], 1'b0, regWrData[2:0]};
          `CIS_OFS_IRQ_MASK: irqMask_reg <= regWrData[5:0];
          `CIS_OFS_PW_LIMIT: pwLimit_reg <= regWrData;
          `CIS_OFS_CHATTER: chatter_reg <= {20'h0, regWrData[11:0]};
          `CIS_OFS_CFG_PTR: cfgPtr_reg <= regWrData[4:0];
          `CIS_OFS_CFG_DATA: cfgMem[cfgPtr_reg] <= regWrData[5:0]; // [R3]
          default: ;
        endcase
      end
    end
  end

  assign irq = |(irqStat_reg & irqMask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Register reads: data one cycle after the strobe, zero otherwise
  reg [31:0] statusView;
  always @*
  begin
    for (j = 0; j < POINTS; j = j + 1)
      statusView[j] = filtLvl_reg[j] & cfgMem[j][`CIS_CFG_STATUS]; // [R3]
  end

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      regRdData <= 32'h0;
    else if (!regRdStb)
      regRdData <= 32'h0;
    else
    begin
      case (regAddr)
        `CIS_OFS_CTRL: regRdData <= ctrl_reg;
        `CIS_OFS_STATUS: regRdData <= statusView;
        `CIS_OFS_CHANGE: regRdData <= change_reg; // [R16]
        `CIS_OFS_IRQ_STAT: regRdData <= {26'h0, irqStat_reg};
        `CIS_OFS_IRQ_MASK: regRdData <= {26'h0, irqMask_reg};
        `CIS_OFS_PW_LIMIT: regRdData <= pwLimit_reg;
        `CIS_OFS_CHATTER: regRdData <= chatter_reg;
        `CIS_OFS_CFG_PTR: regRdData <= {27'h0, cfgPtr_reg};
        `CIS_OFS_CFG_DATA: regRdData <= {26'h0, cfgMem[cfgPtr_reg]};
        `CIS_OFS_ACC_DATA: regRdData <= {8'h0, accMem[cfgPtr_reg]}; // [R4]
        `CIS_OFS_EVT_COUNT: regRdData <= {28'h0, evtCount_reg};
        `CIS_OFS_EVT_TIME: regRdData <= {8'h0, evtMem[evtRd_reg][23:0]};
        `CIS_OFS_EVT_INFO: regRdData <= {(evtCount_reg != 4'h0), 22'h0,
          evtMem[evtRd_reg][24], 3'h0, evtMem[evtRd_reg][29:25]}; // [R5]
        `CIS_OFS_ADC_BASE: regRdData <= {19'h0, adcRes[0]}; // [R14]
        `CIS_OFS_ADC_BASE + 8'h04: regRdData <= {19'h0, adcRes[1]};
        `CIS_OFS_ADC_BASE + 8'h08: regRdData <= {19'h0, adcRes[2]};
        `CIS_OFS_ADC_BASE + 8'h0c: regRdData <= {19'h0, adcRes[3]};
        `CIS_OFS_ADC_BASE + 8'h10: regRdData <= {19'h0, adcRes[4]}; // [R15]
        `CIS_OFS_ADC_BASE + 8'h14: regRdData <= {19'h0, adcRes[5]};
        default: regRdData <= 32'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** testbench/cis_scanner_properties.sv ***
/*
  Port checker for the contact input scanner, bound to its top module.
  Assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cis_scanner_chk #(
  parameter TICK_CYCLES = 250000
)(
  input wire clock,
  input wire arst_n,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  input wire [31:0] regRdData,
  input wire [2:0] adcMuxSel,
  input wire adcStart,
  input wire irq
);
  // One converter slot in clock cycles
  localparam int SLOT = 80 * TICK_CYCLES;
  // Cycles since the last slot start
  int gapCnt_reg;
  // First start has no reference, so the gap check waits for it
  logic seen_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Slot gap counter
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gapCnt_reg <= 0;
      seen_reg <= 1'b0;
    end
    else
    begin
      gapCnt_reg <= adcStart ? 0 : gapCnt_reg + 1;
      seen_reg <= seen_reg | adcStart;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  chk_rd_idle: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
    else $error("read data not idle");
  chk_unmapped_rd: assert property (regRdStb && regAddr == 8'h3c |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  chk_mask_off: assert property (regWrStb && regAddr == 8'h10 && regWrData == 32'h0 |=> !irq)
    else $error("irq high with all masked");
  chk_start_pulse: assert property (adcStart |=> !adcStart)
    else $error("start longer than one cycle");
  chk_mux_hold: assert property (adcStart |=> $stable(adcMuxSel) [*8])
    else $error("channel moved inside slot");
  chk_mux_range: assert property (adcMuxSel <= 3'h5)
    else $error("channel out of range");
  chk_mux_order: assert property ($changed(adcMuxSel) |->
    adcMuxSel == 3'h0 || adcMuxSel == $past(adcMuxSel) + 3'h1)
    else $error("channel order broken");
  chk_slot_gap: assert property (adcStart && seen_reg |-> gapCnt_reg == SLOT - 1)
    else $error("slot length wrong");
  cover property (adcStart && adcMuxSel == 3'h5);
  cover property (regRdStb && regAddr == 8'h30);
  cover property (irq);
endmodule
bind cis_scanner cis_scanner_chk #(.TICK_CYCLES(TICK_CYCLES)) u_cis_scanner_chk (
  .clock(clock), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .adcMuxSel(adcMuxSel), .adcStart(adcStart), .irq(irq));
`default_nettype wire

// *** testbench/cis_adc_model.sv ***
/*
  Behavioural dual-slope converter answering each slot start.
  Assumes the scanner holds the channel select for the whole slot.
*/
`timescale 1ns/1ps
`default_nettype none
module cis_adc_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [2:0] adcMuxSel,
  input wire logic adcStart,
  input wire logic slowMode,
  output logic adcDone,
  output logic [12:0] adcData
);
  // Raw readings: 100, -300, 4090, -4000, zero ref 10, full-scale ref 2000
  logic [12:0] rawTab [0:5] = '{13'h0064, 13'h1ed4, 13'h0ffa, 13'h1060, 13'h000a, 13'h07d0};
  logic [12:0] last_reg;
  int waitCnt_reg;
  // Outside the done pulse the bus shows garbage, so a late sample fails
  assign adcData = adcDone ? last_reg : ~last_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Conversion delay, prompt or slow
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitCnt_reg <= 0;
      adcDone <= 1'b0;
      last_reg <= '0;
    end
    else
    begin
      adcDone <= (waitCnt_reg == 1);
      if (waitCnt_reg == 1)
        last_reg <= rawTab[adcMuxSel];
      if (adcStart)
        waitCnt_reg <= slowMode ? 200 : 3;
      else if (waitCnt_reg != 0)
        waitCnt_reg <= waitCnt_reg - 1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/cis_scanner_tb.sv ***
/*
  Self-checking bench for the contact input scanner.
  Assumes a 40-cycle millisecond tick and the converter model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CIS_CHECK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module cis_scanner_tb;
  // The 33-cycle point walk must fit inside one tick, or scans are skipped
  localparam int TICK = 40;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] contactIn = '0;
  logic [7:0] regAddr = '0;
  logic [31:0] regWrData = '0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic slowMode = 1'b0;
  logic [31:0] regRdData;
  logic [2:0] adcMuxSel;
  logic adcStart;
  logic adcDone;
  logic [12:0] adcData;
  logic irq;
  logic [31:0] rdv, t1, base, n;
  int bad_count = 0;
  int compares = 0;
  // Expected results: zero-corrected and saturated fields, then raw refs
  logic [12:0] adcExp [0:5] = '{13'h005a, 13'h1eca, 13'h07ff, 13'h1801, 13'h000a, 13'h07d0};
  cis_scanner #(.TICK_CYCLES(TICK)) u_cis_scanner (.clock(clock), .arst_n(arst_n),
    .contactIn(contactIn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .adcMuxSel(adcMuxSel), .adcStart(adcStart), .adcDone(adcDone),
    .adcData(adcData), .irq(irq));
  cis_adc_model u_cis_adc_model (.clock(clock), .arst_n(arst_n), .adcMuxSel(adcMuxSel),
    .adcStart(adcStart), .slowMode(slowMode), .adcDone(adcDone), .adcData(adcData));
  always #2 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  // Bus and timing helpers; each ends on a rising edge with strobes low
  task automatic ticks(input int k);
    repeat (k * TICK) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
    @(posedge clock);
  endtask
  // Data stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    @(negedge clock);
    d = regRdData;
    @(posedge clock);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd(a, rdv);
    `CIS_CHECK(rdv, e)
  endtask
  // Pulse train kept below the field toggle limit
  task automatic pulses(input int b, input int cnt, input int w);
    repeat (cnt)
    begin
      contactIn[b] <= 1'b1;
      ticks(w);
      contactIn[b] <= 1'b0;
      ticks(w);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_defaults;
    chk_rd(8'h00, 32'h0);
    chk_rd(8'h14, 32'hffff_0000);
    chk_rd(8'h18, 32'h0000_0864);
    chk_rd(8'h3c, 32'h0);
    // Mixed point kinds on one module
    for (int i = 0; i < 32; i++)
    begin
      wr(8'h1c, 32'(i));
      wr(8'h20, i == 0 ? 32'h17 : i == 1 ? 32'h23 : i == 2 ? 32'h2 : 32'h1);
    end
    wr(8'h00, 32'h3);
    $display("defaults done");
  endtask
  task automatic t_debounce;
    contactIn[2:0] <= 3'h5;
    ticks(1);
    contactIn[2:0] <= 3'h0;
    ticks(5);
    chk_rd(8'h04, 32'h0);
    chk_rd(8'h08, 32'h0);
    contactIn[2:0] <= 3'h5;
    ticks(5);
    chk_rd(8'h04, 32'h1);
    chk_rd(8'h08, 32'h5);
    chk_rd(8'h08, 32'h0);
    wr(8'h10, 32'h4);
    `CIS_CHECK(irq, 1'b1)
    wr(8'h0c, 32'h1f);
    `CIS_CHECK(irq, 1'b0)
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h23);
    ticks(5);
    chk_rd(8'h04, 32'h0000_ff01);
    wr(8'h00, 32'h3);
    ticks(5);
    $display("debounce done");
  endtask
  task automatic t_count;
    contactIn[0] <= 1'b0;
    ticks(8);
    rd(8'h28, n);
    repeat (n) rd(8'h30, rdv);
    wr(8'h1c, 32'h0);
    rd(8'h24, base);
    pulses(0, 3, 8);
    chk_rd(8'h24, base + 32'd3);
    chk_rd(8'h28, 32'd6);
    rd(8'h2c, t1);
    chk_rd(8'h30, 32'h8000_0100);
    rd(8'h2c, rdv);
    `CIS_CHECK(rdv - t1, 32'd8)
    chk_rd(8'h30, 32'h8000_0000);
    // Width window 20..30 ms: an 8 ms pulse is dropped, a 25 ms one counted
    wr(8'h14, 32'h001e_0014);
    rd(8'h24, base);
    pulses(0, 1, 8);
    ticks(25);
    pulses(0, 1, 25);
    chk_rd(8'h24, base + 32'd1);
    // Four more edges overflow the eight-entry event store
    pulses(0, 2, 25);
    chk_rd(8'h28, 32'd8);
    rd(8'h0c, rdv);
    `CIS_CHECK(rdv[1], 1'b1)
    $display("count done");
  endtask
  task automatic t_chatter;
    // Open the width window again and clear the chatter flag first
    wr(8'h14, 32'hffff_0000);
    wr(8'h0c, 32'h10);
    pulses(1, 12, 4);
    ticks(110);
    rd(8'h0c, rdv);
    `CIS_CHECK(rdv[4], 1'b1)
    $display("chatter done");
  endtask
  task automatic t_adc;
    slowMode <= 1'b1;
    wr(8'h0c, 32'h8);
    ticks(700);
    for (int c = 0; c < 6; c++)
    begin
      rd(8'h40 + 8'(4 * c), rdv);
      `CIS_CHECK(rdv[12:0], adcExp[c])
    end
    rd(8'h0c, rdv);
    `CIS_CHECK(rdv[3], 1'b1)
    // Unipolar range clips negatives to zero and keeps 4080 whole
    wr(8'h00, 32'h7);
    ticks(500);
    chk_rd(8'h44, 32'h0);
    chk_rd(8'h48, 32'h0ff0);
    $display("converter done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    t_defaults();
    t_debounce();
    t_count();
    t_chatter();
    t_adc();
    conclude();
  end
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clock);
    bad_count++;
    $display("ERROR %0t: run limit reached", $time);
    conclude();
  end
endmodule
`default_nettype wire
